/* File: src/opp_params.svh */
// Purpose: constants for the 6800-style parallel display port
// Assumes: 100 MHz system clock on both ends
// Notes: strobe timing figures are in nanoseconds
`ifndef OPP_PARAMS_SVH
`define OPP_PARAMS_SVH
`define OPP_CLK_NS 10
`define OPP_SETUP_NS 20
`define OPP_SETUP_CYC ((`OPP_SETUP_NS + `OPP_CLK_NS - 1) / `OPP_CLK_NS)
`define OPP_HIGH_NS 60
`define OPP_HIGH_CYC ((`OPP_HIGH_NS + `OPP_CLK_NS - 1) / `OPP_CLK_NS)
`define OPP_HOLD_NS 20
`define OPP_HOLD_CYC ((`OPP_HOLD_NS + `OPP_CLK_NS - 1) / `OPP_CLK_NS)
`define OPP_CNT_W 4
// A phase lasts one cycle longer than its counter load
`define OPP_SETUP_LOAD (`OPP_SETUP_CYC + 1)
`define OPP_HIGH_LOAD (`OPP_HIGH_CYC + 2)
`define OPP_HOLD_LOAD (`OPP_HOLD_CYC + 2)
`define OPP_BUS_W 8
`define OPP_SYNC_STAGES 2
// Layout of one synchronised pin sample
`define OPP_SYNC_W 14
`define OPP_POS_BUS_LO 0
`define OPP_POS_BUS_HI 7
`define OPP_POS_CS_N 8
`define OPP_POS_DC 9
`define OPP_POS_STROBE 10
`define OPP_POS_RW 11
`define OPP_POS_INIT 12
`define OPP_POS_OFF_N 13
`define OPP_DC_DATA 1'h1
`define OPP_DC_CMD 1'h0
`define OPP_RW_READ 1'h1
`define OPP_RW_WRITE 1'h0
`endif

/* File: src/opp_pkg.sv */
// Purpose: shared types for the parallel display port
// Assumes: nothing
// Notes: timing constants live in opp_params.svh
package opp_pkg;
  typedef enum logic [1:0] {
    OPP_IDLE, OPP_SETUP, OPP_HIGH, OPP_HOLD
  } opp_state_t;
endpackage

/* File: src/opp_if.sv */
// Purpose: pins between host and display-side port
// Assumes: testbench resolves the shared data bus from the enables
// Notes: two-way bus split into in, out and enable per party
`timescale 1ns/100ps
interface opp_if;
  logic cs_n;
  logic dc;
  logic rw;
  logic strobe;
  logic init_low;
  logic converter_off_n;
  logic [7:0] host_d_o;
  logic host_d_oe;
  logic [7:0] dev_d_o;
  logic dev_d_oe;
  logic [7:0] bus_d;
  modport host (output cs_n, dc, rw, strobe, init_low, converter_off_n,
    host_d_o, host_d_oe, input bus_d);
  modport dev (input cs_n, dc, rw, strobe, init_low, converter_off_n,
    output dev_d_o, dev_d_oe, input bus_d);
endinterface

/* File: src/opp_device.sv */
// Purpose: display-side end of the 6800-style parallel port
// Assumes: pins arrive asynchronously; all pass two flip-flops except the raw strobe, cs_n and rw that gate the read drive
// Notes: a read presents RD_DATA_I, which user logic keeps current
`timescale 1ns/100ps
`include "opp_params.svh"

module opp_device #(
  parameter int DATA_W = `OPP_BUS_W,
  parameter int SYNC_STAGES = `OPP_SYNC_STAGES
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  opp_if.dev PIN,
  input wire logic SHUTDOWN_JUMPER_I,
  input wire logic [7:0] RD_DATA_I,
  output logic WR_VALID_O,
  output logic WR_IS_DATA_O,
  output logic [7:0] WR_BYTE_O,
  output logic RD_DONE_O,
  output logic RD_IS_DATA_O,
  output logic INIT_O,
  output logic CONVERTER_ON_O
);
  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  // The interface and the sample layout are one byte wide
  if (DATA_W != `OPP_BUS_W) begin : g_bad_width
    $error("opp_device: DATA_W must equal the bus width");
  end
  // A single flop would let a metastable level reach the decode
  if (SYNC_STAGES < `OPP_SYNC_STAGES) begin : g_bad_sync
    $error("opp_device: SYNC_STAGES must be at least two");
  end

  localparam int SYNC_W = `OPP_SYNC_W;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic sel_is_data(input logic dc_v);
    return (dc_v == `OPP_DC_DATA);
  endfunction

  function automatic logic sel_is_read(input logic rw_v);
    return (rw_v == `OPP_RW_READ);
  endfunction

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  // All pins share one chain depth, so the fields of a sample
  // belong to the same edge and never mix two accesses
  wire [SYNC_W-1:0] pin_raw;
  wire [SYNC_W-1:0] pin_s;
  assign pin_raw[`OPP_POS_BUS_HI:`OPP_POS_BUS_LO] = PIN.bus_d;
  assign pin_raw[`OPP_POS_CS_N] = PIN.cs_n;
  assign pin_raw[`OPP_POS_DC] = PIN.dc;
  assign pin_raw[`OPP_POS_STROBE] = PIN.strobe;
  assign pin_raw[`OPP_POS_RW] = PIN.rw;
  assign pin_raw[`OPP_POS_INIT] = PIN.init_low;
  assign pin_raw[`OPP_POS_OFF_N] = PIN.converter_off_n;

  for (genvar b = 0; b < SYNC_W; b++) begin : g_sync
    logic [SYNC_STAGES-1:0] chain_r;
    always_ff @(posedge CLK_I) begin
      chain_r <= {chain_r[SYNC_STAGES-2:0], pin_raw[b]};
    end
    assign pin_s[b] = chain_r[SYNC_STAGES-1];
  end

  wire [DATA_W-1:0] bus_s = pin_s[`OPP_POS_BUS_HI:`OPP_POS_BUS_LO];
  wire cs_n_s = pin_s[`OPP_POS_CS_N];
  wire dc_s = pin_s[`OPP_POS_DC];
  wire strobe_s = pin_s[`OPP_POS_STROBE];
  wire rw_s = pin_s[`OPP_POS_RW];
  wire init_low_s = pin_s[`OPP_POS_INIT];
  wire off_n_s = pin_s[`OPP_POS_OFF_N];

  // ----------------------------------------
  // Strobe edges
  // ----------------------------------------
  // The history resets to the idle low level, so no false fall
  // appears when reset lifts
  logic strobe_d_r;
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      strobe_d_r <= 1'h0;
    end else begin
      strobe_d_r <= strobe_s;
    end
  end

  wire rise = strobe_s && !strobe_d_r;
  wire fall = strobe_d_r && !strobe_s;

  // ----------------------------------------
  // Access tracking
  // ----------------------------------------
  // An access counts only if chip select was already low when the
  // strobe rose; a strobe caught halfway is ignored. The selectors
  // are taken at the rise, where the host has let them settle.
  logic open_r;
  logic dc_at_rise_r;
  logic rw_at_rise_r;
  wire in_reset = RST_I || !init_low_s;
  wire sel = !cs_n_s;
  wire open_set = rise && sel;
  wire open_nxt = open_set || (open_r && !fall);

  always_ff @(posedge CLK_I) begin
    if (in_reset) begin
      open_r <= 1'h0;
    end else begin
      open_r <= open_nxt;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (in_reset) begin
      dc_at_rise_r <= `OPP_DC_CMD;
      rw_at_rise_r <= `OPP_RW_READ;
    end else if (open_set) begin
      dc_at_rise_r <= dc_s;
      rw_at_rise_r <= rw_s;
    end
  end

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire take_fall = open_r && sel && fall;
  wire wr_evt = take_fall && !sel_is_read(rw_at_rise_r);
  wire rd_evt = take_fall && sel_is_read(rw_at_rise_r);
  // With the jumper open the shutdown pin is ignored
  wire conv_on = !SHUTDOWN_JUMPER_I || off_n_s;

  // The drive follows the raw pins: a synchronised copy would hold
  // the bus for two cycles after the host has lowered the strobe
  wire rd_window = PIN.strobe && !PIN.cs_n;
  wire drive = rd_window && sel_is_read(PIN.rw) && !in_reset;
  assign PIN.dev_d_oe = drive;
  assign PIN.dev_d_o = RD_DATA_I;

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_ff @(posedge CLK_I) begin
    if (in_reset) begin
      WR_VALID_O <= 1'h0;
    end else begin
      WR_VALID_O <= wr_evt;
    end
  end

  // The byte and its kind stand until the next accepted write
  always_ff @(posedge CLK_I) begin
    if (in_reset) begin
      WR_BYTE_O <= 8'h00;
      WR_IS_DATA_O <= 1'h0;
    end else if (wr_evt) begin
      WR_BYTE_O <= bus_s;
      WR_IS_DATA_O <= sel_is_data(dc_at_rise_r);
    end
  end

  // A read is reported once the host has lowered the strobe
  always_ff @(posedge CLK_I) begin
    if (in_reset) begin
      RD_DONE_O <= 1'h0;
    end else begin
      RD_DONE_O <= rd_evt;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (in_reset) begin
      RD_IS_DATA_O <= 1'h0;
    end else if (rd_evt) begin
      RD_IS_DATA_O <= sel_is_data(dc_at_rise_r);
    end
  end

  // Reported even while the init pin holds the capture logic down
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      INIT_O <= 1'h1;
    end else begin
      INIT_O <= !init_low_s;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      CONVERTER_ON_O <= 1'h0;
    end else begin
      CONVERTER_ON_O <= conv_on;
    end
  end
endmodule

/* File: src/opp_host.sv */
// Purpose: host end issuing 6800-style reads and writes
// Assumes: device samples pins through synchronisers
// Notes: one request at a time; READY_O high when idle
`timescale 1ns/100ps
`include "opp_params.svh"
module opp_host (
  input wire logic CLK_I,
  input wire logic RST_I,
  opp_if.host PIN,
  input wire logic REQ_I,
  input wire logic REQ_READ_I,
  input wire logic REQ_DATA_I,
  input wire logic [7:0] REQ_BYTE_I,
  input wire logic INIT_REQ_I,
  input wire logic CONVERTER_ON_I,
  output logic READY_O,
  output logic RD_VALID_O,
  output logic [7:0] RD_BYTE_O
);
  opp_pkg::opp_state_t st_r, st_nxt;
  logic [`OPP_CNT_W-1:0] cnt_r;
  logic cs_n_r, dc_r, rw_r, strobe_r, oe_r, init_r, conv_r;
  logic [7:0] d_r;
  logic [7:0] b1_r, b2_r;

  // Strobe phases are long so the synchronised device still sees them
  wire cnt_done = (cnt_r == '0);
  wire take = (st_r == opp_pkg::OPP_IDLE) && REQ_I;

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      opp_pkg::OPP_IDLE: if (REQ_I) st_nxt = opp_pkg::OPP_SETUP;
      opp_pkg::OPP_SETUP: if (cnt_done) st_nxt = opp_pkg::OPP_HIGH;
      opp_pkg::OPP_HIGH: if (cnt_done) st_nxt = opp_pkg::OPP_HOLD;
      opp_pkg::OPP_HOLD: if (cnt_done) st_nxt = opp_pkg::OPP_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    b1_r <= PIN.bus_d;
    b2_r <= b1_r;
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      st_r <= opp_pkg::OPP_IDLE;
      cnt_r <= '0;
      cs_n_r <= 1'h1;
      dc_r <= 1'h0;
      rw_r <= 1'h1;
      strobe_r <= 1'h0;
      oe_r <= 1'h0;
      d_r <= 8'h00;
      init_r <= 1'h0;
      conv_r <= 1'h0;
      READY_O <= 1'h0;
      RD_VALID_O <= 1'h0;
      RD_BYTE_O <= 8'h00;
    end else begin
      st_r <= st_nxt;
      init_r <= !INIT_REQ_I;
      conv_r <= CONVERTER_ON_I;
      RD_VALID_O <= 1'h0;
      READY_O <= (st_nxt == opp_pkg::OPP_IDLE);
      if (!cnt_done) cnt_r <= cnt_r - 1'h1;
      if (take) begin
        // Controls settle before the strobe rises
        cs_n_r <= 1'h0;
        dc_r <= REQ_DATA_I;
        rw_r <= REQ_READ_I;
        d_r <= REQ_BYTE_I;
        oe_r <= !REQ_READ_I;
        cnt_r <= `OPP_CNT_W'(`OPP_SETUP_LOAD);
      end
      if (st_r == opp_pkg::OPP_SETUP && cnt_done) begin
        strobe_r <= 1'h1;
        cnt_r <= `OPP_CNT_W'(`OPP_HIGH_LOAD);
      end
      if (st_r == opp_pkg::OPP_HIGH && cnt_done) begin
        strobe_r <= 1'h0;
        cnt_r <= `OPP_CNT_W'(`OPP_HOLD_LOAD);
        if (rw_r == `OPP_RW_READ) begin
          RD_VALID_O <= 1'h1;
          RD_BYTE_O <= b2_r;
        end
      end
      if (st_r == opp_pkg::OPP_HOLD && cnt_done) begin
        cs_n_r <= 1'h1;
        oe_r <= 1'h0;
        rw_r <= 1'h1;
      end
    end
  end

  assign PIN.cs_n = cs_n_r;
  assign PIN.dc = dc_r;
  assign PIN.rw = rw_r;
  assign PIN.strobe = strobe_r;
  assign PIN.host_d_o = d_r;
  assign PIN.host_d_oe = oe_r;
  assign PIN.init_low = init_r;
  assign PIN.converter_off_n = conv_r;
endmodule

/* File: bench/opp_assertions.sv */
// Purpose: wire checks between host and device ends
// Assumes: one 100 MHz clock, setup 4, high 9, hold 5
// Notes: watches the shared interface only
`timescale 1ns/100ps
module opp_assertions (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic cs_n,
  input wire logic dc,
  input wire logic rw,
  input wire logic strobe,
  input wire logic [7:0] host_d_o,
  input wire logic host_d_oe,
  input wire logic dev_d_oe
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  a_dev_drive_sel: assert property (
    dev_d_oe |-> !cs_n && rw && strobe)
    else $error("device drove bus outside read strobe");
  a_one_driver: assert property (!(dev_d_oe && host_d_oe))
    else $error("both ends drove the bus");
  a_write_dir: assert property (host_d_oe |-> !rw)
    else $error("host drove bus on a read");
  a_strobe_sel: assert property (strobe |-> !cs_n)
    else $error("strobe without chip select");
  a_ctrl_steady: assert property (strobe && $past(strobe) |->
    $stable({cs_n, dc, rw})) else $error("controls moved under strobe");
  a_setup_gap: assert property (
    $rose(strobe) |-> $past(cs_n, 4) == 1'h0)
    else $error("setup too short");
  a_strobe_width: assert property (
    $rose(strobe) |-> strobe[*8] ##1 strobe ##1 !strobe)
    else $error("strobe width wrong");
  a_wr_hold: assert property ($fell(strobe) && !rw |-> host_d_oe &&
    $stable(host_d_o)) else $error("write data not held over fall");
  a_cs_hold: assert property ($fell(strobe) |-> !cs_n[*5] ##1 cs_n)
    else $error("hold phase wrong");
  a_rd_release: assert property ($fell(strobe) && rw |-> !dev_d_oe)
    else $error("device kept bus after strobe");
  c_read: cover property ($fell(strobe) && rw);
  c_wr_data: cover property ($fell(strobe) && !rw && dc);
  c_wr_cmd: cover property ($fell(strobe) && !rw && !dc);
endmodule

/* File: bench/tb.sv */
// Purpose: host and device ends joined back to back
// Assumes: notes queued by the driver, checked by a monitor
// Notes: a released bus shows the inverse of its last value
`timescale 1ns/100ps
`define CHK(n, e, g) check(n, 9'(e), 9'(g))
module tb;
  logic clk = 0, rst = 1, req = 0, req_rd = 0, req_dc = 0;
  logic init_req = 0, conv_on = 1, jmp = 0;
  logic [7:0] req_b = 8'h00, rd_data = 8'h00, last_bus = 8'h00;
  logic ready, rd_valid, wr_valid, wr_is_data, rd_done, rd_is_data;
  logic init_o, conv_o;
  logic [7:0] rd_byte, wr_byte;
  logic [8:0] wq[$];
  logic [8:0] rq[$];
  logic [8:0] dq[$];
  int n_errors = 0, num_checks = 0, i;
  opp_if u_if ();
  assign u_if.bus_d = u_if.dev_d_oe ? u_if.dev_d_o :
    u_if.host_d_oe ? u_if.host_d_o : ~last_bus;
  always @(posedge clk) last_bus <= u_if.bus_d;
  initial forever #5 clk = ~clk;
  opp_host i_opp_host (.CLK_I(clk), .RST_I(rst), .PIN(u_if), .REQ_I(req),
    .REQ_READ_I(req_rd), .REQ_DATA_I(req_dc), .REQ_BYTE_I(req_b),
    .INIT_REQ_I(init_req), .CONVERTER_ON_I(conv_on), .READY_O(ready),
    .RD_VALID_O(rd_valid), .RD_BYTE_O(rd_byte));
  opp_device i_opp_device (.CLK_I(clk), .RST_I(rst), .PIN(u_if),
    .SHUTDOWN_JUMPER_I(jmp), .RD_DATA_I(rd_data), .WR_VALID_O(wr_valid),
    .WR_IS_DATA_O(wr_is_data), .WR_BYTE_O(wr_byte), .RD_DONE_O(rd_done),
    .RD_IS_DATA_O(rd_is_data), .INIT_O(init_o), .CONVERTER_ON_O(conv_o));
  opp_assertions i_opp_assertions (.CLK_I(clk), .RST_I(rst),
    .cs_n(u_if.cs_n), .dc(u_if.dc), .rw(u_if.rw), .strobe(u_if.strobe),
    .host_d_o(u_if.host_d_o), .host_d_oe(u_if.host_d_oe),
    .dev_d_oe(u_if.dev_d_oe));
  task check(input string n, input logic [8:0] e, input logic [8:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task wait_ready;
    for (int k = 0; k < 40 && ready !== 1'b1; k++) @(posedge clk);
    `CHK("ready", 1'b1, ready);
  endtask
  // Back to back: the next request goes in as soon as ready returns
  task xfer(input logic rd, input logic d, input logic [7:0] b);
    wait_ready();
    req <= 1'b1;
    req_rd <= rd;
    req_dc <= d;
    req_b <= b;
    rd_data <= b;
    if (rd) begin
      rq.push_back({1'b0, b});
      dq.push_back({8'h00, d});
    end else wq.push_back({d, b});
    @(posedge clk);
    req <= 1'b0;
    @(posedge clk);
  endtask
  // ----------------
  // Monitor
  // ----------------
  always @(posedge clk) begin
    if (wr_valid === 1'b1)
      `CHK("wr", wq.pop_front(), {wr_is_data, wr_byte});
    if (rd_valid === 1'b1)
      `CHK("rd", rq.pop_front(), rd_byte);
    if (rd_done === 1'b1)
      `CHK("rd_dc", dq.pop_front(), rd_is_data);
  end
  initial begin
    void'($urandom(58782));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    for (i = 0; i < 32; i++) xfer(i[4], i[0], 8'($urandom));
    wait_ready();
    $display("test transfers done");
    for (i = 0; i < 4; i++) begin
      jmp <= i[1];
      conv_on <= i[0];
      repeat (6) @(posedge clk);
      `CHK("conv", !i[1] || i[0], conv_o);
    end
    $display("test converter done");
    init_req <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK("init", 1'b1, init_o);
    init_req <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK("init", 1'b0, init_o);
    xfer(1'b0, 1'b1, 8'hA5);
    wait_ready();
    $display("test init done");
    `CHK("wq_left", 9'h000, wq.size());
    `CHK("rq_left", 9'h000, rq.size());
    `CHK("dq_left", 9'h000, dq.size());
    print_verdict();
  end
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    print_verdict();
  end
endmodule
